/* File: verilog/sar_host.sv */
/*
  Host end: start, hold control, byte-wise read, overrange check and
  two-point calibration (ground channel, then reference channel).
  Assumes the converter end answers on the shared link interface.
*/
`timescale 1ns/1ns
module sar_host (
  input  wire logic        ref_clk_in,
  input  wire logic        rst_in,
  input  wire logic        conv_req_in,
  input  wire logic        cal_req_in,
  input  wire logic [2:0]  conv_channel_in,
  output logic [2:0]       mux_channel_out,
  output logic             hold_out,
  output logic             busy_out,
  output logic             done_out,
  output logic [14:0]      sample_out,
  output logic             sample_bad_out,
  output logic [13:0]      offset_out,
  output logic [13:0]      span_out,
  sar_link_if.host         link
);
  typedef enum logic [5:0] {
    H_IDLE = 6'b000001,
    H_WR   = 6'b000010,
    H_WAIT = 6'b000100,
    H_RDLO = 6'b001000,
    H_RDHI = 6'b010000,
    H_DONE = 6'b100000
  } host_state_type;

  host_state_type st_reg, st_next;
  logic [2:0]  ch_reg, ch_next;
  logic        hold_reg, hold_next;
  logic        cal_reg, cal_next;
  logic        cal_ref_reg, cal_ref_next;
  logic        done_reg, done_next;
  logic [7:0]  lo_reg, lo_next;
  logic [14:0] sample_reg, sample_next;
  logic        bad_reg, bad_next;
  logic [13:0] offset_reg, offset_next;
  logic [13:0] span_reg, span_next;
  logic        wr_n_reg, wr_n_next;
  logic        rd_n_reg, rd_n_next;
  logic        cs_n_reg, cs_n_next;
  logic        bsel_reg, bsel_next;
  logic        eoc_d_reg;
  logic        settle_reg, settle_next;
  logic        busy_reg, busy_next;
  logic [14:0] full;

  assign full = {link.data_bus[7], link.data_bus[5:0], lo_reg};

  // Host transaction sequencer
  always_comb begin
    st_next      = st_reg;
    ch_next      = ch_reg;
    hold_next    = hold_reg;
    cal_next     = cal_reg;
    cal_ref_next = cal_ref_reg;
    done_next    = 1'b0;
    lo_next      = lo_reg;
    sample_next  = sample_reg;
    bad_next     = bad_reg;
    offset_next  = offset_reg;
    span_next    = span_reg;
    wr_n_next    = 1'b1;
    rd_n_next    = 1'b1;
    cs_n_next    = 1'b1;
    bsel_next    = sar_pkg::BYTE_SEL_LOW;
    settle_next  = 1'b0;
    // Hold clears when end-of-conversion rises
    if (link.eoc && !eoc_d_reg) begin
      hold_next = 1'b0;
    end
    case (st_reg)
      H_IDLE: begin
        if (cal_req_in) begin
          cal_next     = 1'b1;
          cal_ref_next = 1'b0;
          ch_next      = sar_pkg::CH_GROUND;
          st_next      = H_WR;
        end else if (conv_req_in) begin
          cal_next = 1'b0;
          ch_next  = conv_channel_in;
          st_next  = H_WR;
        end
      end
      H_WR: begin
        cs_n_next = 1'b0;
        wr_n_next = 1'b0;
        hold_next = 1'b1;
        st_next   = H_WAIT;
      end
      H_WAIT: begin
        // Eoc may still show the old high level one cycle after write
        if (link.eoc && !hold_reg) begin
          cs_n_next = 1'b0;
          rd_n_next = 1'b0;
          bsel_next = sar_pkg::BYTE_SEL_LOW;
          st_next   = H_RDLO;
        end
      end
      H_RDLO: begin
        cs_n_next   = 1'b0;
        rd_n_next   = 1'b0;
        bsel_next   = sar_pkg::BYTE_SEL_LOW;
        // Converter registers the bus a cycle after the strobes: wait one
        settle_next = 1'b1;
        if (settle_reg) begin
          lo_next     = link.data_bus[7:0];
          bsel_next   = 1'b1;
          settle_next = 1'b0;
          st_next     = H_RDHI;
        end
      end
      H_RDHI: begin
        cs_n_next   = 1'b0;
        rd_n_next   = 1'b0;
        bsel_next   = 1'b1;
        // Same one-cycle wait after the byte select change
        settle_next = 1'b1;
        if (settle_reg) begin
          settle_next = 1'b0;
          sample_next = full;
          // Overrange: keep only 100..103 percent results
          bad_next = full[14] && ({3'h0, full[13:0]} + sar_pkg::FULL_SCALE > sar_pkg::OVR_LIMIT);
          cs_n_next = 1'b1;
          rd_n_next = 1'b1;
          st_next   = H_DONE;
        end
      end
      H_DONE: begin
        if (cal_reg && !cal_ref_reg) begin
          offset_next  = sample_reg[13:0];
          cal_ref_next = 1'b1;
          ch_next      = sar_pkg::CH_REFERENCE;
          st_next      = H_WR;
        end else begin
          if (cal_reg) begin
            span_next = sample_reg[13:0] - offset_reg;
          end
          cal_next  = 1'b0;
          done_next = 1'b1;
          st_next   = H_IDLE;
        end
      end
      default: begin
        st_next = H_IDLE;
      end
    endcase
    // Busy registered so the port comes straight from a flip-flop
    busy_next = (st_next != H_IDLE);
  end

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      st_reg      <= H_IDLE;
      ch_reg      <= sar_pkg::CH_GROUND;
      hold_reg    <= 1'b0;
      cal_reg     <= 1'b0;
      cal_ref_reg <= 1'b0;
      done_reg    <= 1'b0;
      lo_reg      <= 8'h00;
      sample_reg  <= 15'h0000;
      bad_reg     <= 1'b0;
      offset_reg  <= sar_pkg::RESULT_ZERO;
      span_reg    <= sar_pkg::RESULT_ZERO;
      wr_n_reg    <= 1'b1;
      rd_n_reg    <= 1'b1;
      cs_n_reg    <= 1'b1;
      bsel_reg    <= sar_pkg::BYTE_SEL_LOW;
      eoc_d_reg   <= 1'b1;
      settle_reg  <= 1'b0;
      busy_reg    <= 1'b0;
    end else begin
      st_reg      <= st_next;
      ch_reg      <= ch_next;
      hold_reg    <= hold_next;
      cal_reg     <= cal_next;
      cal_ref_reg <= cal_ref_next;
      done_reg    <= done_next;
      lo_reg      <= lo_next;
      sample_reg  <= sample_next;
      bad_reg     <= bad_next;
      offset_reg  <= offset_next;
      span_reg    <= span_next;
      wr_n_reg    <= wr_n_next;
      rd_n_reg    <= rd_n_next;
      cs_n_reg    <= cs_n_next;
      bsel_reg    <= bsel_next;
      eoc_d_reg   <= link.eoc;
      settle_reg  <= settle_next;
      busy_reg    <= busy_next;
    end
  end

  assign link.cs_n        = cs_n_reg;
  assign link.rd_n        = rd_n_reg;
  assign link.wr_n        = wr_n_reg;
  assign link.bus_wide    = sar_pkg::BUS_MODE_8;
  assign link.byte_select = bsel_reg;
  assign mux_channel_out  = ch_reg;
  assign hold_out         = hold_reg;
  assign busy_out         = busy_reg;
  assign done_out         = done_reg;
  assign sample_out       = sample_reg;
  assign sample_bad_out   = bad_reg;
  assign offset_out       = offset_reg;
  assign span_out         = span_reg;
endmodule : sar_host

/* File: shared/sar_pkg.sv */
/*
  Shared constants for the converter host port: sizes, conversion timing,
  bus-mode encodings and calibration channels.
  Assumes one 100 MHz clock shared by both ends.
*/
package sar_pkg;
  localparam int          RESULT_W       = 14;
  localparam int          BYTE_W         = 8;
  localparam int          BUS_W          = 16;
  localparam int          CONV_CYCLES    = 20;
  localparam int          AZ_CYCLES      = 3;
  localparam int          CNT_W          = 5;
  localparam int          SAR_W          = 17;
  localparam logic [4:0]  CNT_LAST       = 5'h13;
  localparam logic [4:0]  CNT_AZ_START   = 5'h11;
  localparam logic [4:0]  CNT_ZERO       = 5'h00;
  localparam logic [16:0] ACC_ZERO       = 17'h00000;
  // Full scale, then full scale plus 3 percent of full scale, in result codes
  localparam logic [16:0] FULL_SCALE     = 17'h04000;
  localparam logic [16:0] OVR_LIMIT      = 17'h041EB;
  localparam logic [13:0] RESULT_ZERO    = 14'h0000;
  localparam logic [15:0] BUS_ZERO       = 16'h0000;
  localparam logic [1:0]  BYTE_HI_PAD    = 2'h0;
  localparam logic        BUS_MODE_8     = 1'b0;
  localparam logic        BYTE_SEL_LOW   = 1'b0;
  localparam logic [2:0]  CH_GROUND      = 3'h0;
  localparam logic [2:0]  CH_REFERENCE   = 3'h1;
  localparam logic [15:0] GAIN_UNITY     = 16'h4000;
endpackage : sar_pkg

/* File: shared/sar_link_if.sv */
/*
  Wires between the converter end and the host end: strobes, bus select,
  byte select, shared data bus, end-of-conversion and overrange.
  Assumes both ends sample on the same clock; data bus level resolved here.
*/
`timescale 1ns/1ns
interface sar_link_if;
  logic        cs_n;
  logic        rd_n;
  logic        wr_n;
  logic        bus_wide;
  logic        byte_select;
  logic [15:0] data_drv;
  logic        data_oe;
  logic [15:0] data_bus;
  logic        eoc;
  logic        overrange_flag;

  // Only the converter ever drives the bus; host sees zero when released
  assign data_bus = data_oe ? data_drv : sar_pkg::BUS_ZERO;

  modport converter (input cs_n, input rd_n, input wr_n, input bus_wide, input byte_select,
                     output data_drv, output data_oe, output eoc, output overrange_flag);
  modport host (output cs_n, output rd_n, output wr_n, output bus_wide, output byte_select,
                input data_bus, input eoc, input overrange_flag);
endinterface : sar_link_if

/* File: verilog/sar_converter.sv */
/*
  Converter end: 20-cycle error-correcting approximation sequence,
  output latch, overrange flag and three-state style bus port.
  Assumes the analog comparison arrives as a synchronous level on
  compare_in (1 = input above trial); strobes are synchronous.
*/
`timescale 1ns/1ns
module sar_converter (
  input  wire logic             ref_clk_in,
  input  wire logic             rst_in,
  input  wire logic             compare_in,
  output logic                  auto_zero_out,
  output logic [16:0]           trial_out,
  sar_link_if.converter         link
);
  typedef enum logic [2:0] {
    IDLE_ST = 3'b001,
    CONV_ST = 3'b010,
    ZERO_ST = 3'b100
  } conv_state_type;

  conv_state_type state_reg, state_next;
  logic [4:0]  cnt_reg, cnt_next;
  logic [16:0] acc_reg, acc_next;
  logic [16:0] trial_reg, trial_next;
  logic [13:0] result_reg, result_next;
  logic        ovr_reg, ovr_next;
  logic        eoc_reg, eoc_next;
  logic        az_reg, az_next;
  logic        wr_d_reg;
  logic [15:0] drv_reg, drv_next;
  logic        oe_reg, oe_next;
  logic        start;
  logic        sum_carry;

  // Trial weight for a step: bit pairs x and x-4 first, then single LSBs
  function automatic logic [16:0] step_trial(input logic [4:0] step);
    logic [16:0] t;
    t = sar_pkg::ACC_ZERO;
    if (step < 5'h0D) begin
      t[5'h10 - step] = 1'b1;
      t[5'h0C - step] = 1'b1;
    end else if (step < sar_pkg::CNT_AZ_START) begin
      t[5'h10 - step] = 1'b1;
    end
    return t;
  endfunction : step_trial

  // Start on the falling edge of write while selected
  assign start = !link.wr_n && wr_d_reg && !link.cs_n;

  // Sequencer and accumulator
  always_comb begin
    state_next  = state_reg;
    cnt_next    = cnt_reg;
    acc_next    = acc_reg;
    trial_next  = trial_reg;
    result_next = result_reg;
    ovr_next    = ovr_reg;
    eoc_next    = eoc_reg;
    az_next     = 1'b0;
    sum_carry   = 1'b0;
    case (state_reg)
      IDLE_ST: begin
        if (start) begin
          state_next = CONV_ST;
          cnt_next   = sar_pkg::CNT_ZERO;
          eoc_next   = 1'b0;
          trial_next = step_trial(sar_pkg::CNT_ZERO);
        end
      end
      CONV_ST: begin
        // Comparator says keep the trial; accumulator sums the kept weights.
        // A carry out pins the sum at all ones, so a far overrange input
        // cannot wrap back into the valid range and hide its overrange flag
        if (compare_in) begin
          {sum_carry, acc_next} = {1'b0, acc_reg} + {1'b0, trial_reg};
          if (sum_carry) begin
            acc_next = ~sar_pkg::ACC_ZERO;
          end
        end
        cnt_next   = cnt_reg + 5'h01;
        trial_next = step_trial(cnt_reg + 5'h01);
        if (cnt_reg + 5'h01 == sar_pkg::CNT_AZ_START) begin
          state_next = ZERO_ST;
          az_next    = 1'b1;
        end
      end
      ZERO_ST: begin
        az_next    = 1'b1;
        cnt_next   = cnt_reg + 5'h01;
        trial_next = sar_pkg::ACC_ZERO;
        if (cnt_reg == sar_pkg::CNT_AZ_START) begin
          // Latch result and overrange together before clearing
          ovr_next    = acc_reg >= sar_pkg::FULL_SCALE;
          result_next = (acc_reg >= sar_pkg::FULL_SCALE) ? acc_reg[13:0] : acc_reg[13:0];
          acc_next    = sar_pkg::ACC_ZERO;
        end
        if (cnt_reg == sar_pkg::CNT_LAST) begin
          state_next = IDLE_ST;
          eoc_next   = 1'b1;
          az_next    = 1'b0;
        end
      end
      default: begin
        state_next = IDLE_ST;
      end
    endcase
  end

  // Read path: wide bus gives all bits, byte mode steers by byte select
  always_comb begin
    oe_next  = !link.cs_n && !link.rd_n;
    drv_next = {ovr_reg, eoc_reg, result_reg};
    if (link.bus_wide == sar_pkg::BUS_MODE_8) begin
      if (link.byte_select == sar_pkg::BYTE_SEL_LOW) begin
        drv_next = {8'h00, result_reg[7:0]};
      end else begin
        drv_next = {8'h00, ovr_reg, eoc_reg, result_reg[13:8]};
      end
    end
  end

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_reg  <= IDLE_ST;
      cnt_reg    <= sar_pkg::CNT_ZERO;
      acc_reg    <= sar_pkg::ACC_ZERO;
      trial_reg  <= sar_pkg::ACC_ZERO;
      result_reg <= sar_pkg::RESULT_ZERO;
      ovr_reg    <= 1'b0;
      eoc_reg    <= 1'b1;
      az_reg     <= 1'b0;
      wr_d_reg   <= 1'b1;
      drv_reg    <= sar_pkg::BUS_ZERO;
      oe_reg     <= 1'b0;
    end else begin
      state_reg  <= state_next;
      cnt_reg    <= cnt_next;
      acc_reg    <= acc_next;
      trial_reg  <= trial_next;
      result_reg <= result_next;
      ovr_reg    <= ovr_next;
      eoc_reg    <= eoc_next;
      az_reg     <= az_next;
      wr_d_reg   <= link.wr_n;
      drv_reg    <= drv_next;
      oe_reg     <= oe_next;
    end
  end

  assign link.eoc            = eoc_reg;
  assign link.overrange_flag = ovr_reg;
  assign link.data_drv       = drv_reg;
  assign link.data_oe        = oe_reg;
  assign auto_zero_out       = az_reg;
  assign trial_out           = trial_reg;
endmodule : sar_converter

/* File: tb/sar_link_checker.sv */
/*
  Checker for the converter link: start, conversion length, end-of-conversion,
  overrange latch and bus enable.
  Assumes the bench top instantiates it beside the link interface.
*/
`timescale 1ns/1ns
module sar_link_checker (
  input wire logic        ref_clk_in,
  input wire logic        rst_in,
  input wire logic        cs_n_in,
  input wire logic        rd_n_in,
  input wire logic        wr_n_in,
  input wire logic        bus_wide_in,
  input wire logic        byte_select_in,
  input wire logic [15:0] data_bus_in,
  input wire logic        data_oe_in,
  input wire logic        eoc_in,
  input wire logic        overrange_flag_in
);
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);

  // Falling write with select while idle; writes during a conversion are ignored
  sequence s_start;
    !wr_n_in && !cs_n_in && $past(wr_n_in) && eoc_in;
  endsequence

  // Twenty busy cycles before the result is flagged
  sequence s_busy;
    !eoc_in [*8] ##1 !eoc_in [*8] ##1 !eoc_in [*4];
  endsequence

  AST_EOC_FALLS: assert property (s_start |=> !eoc_in) else $error("eoc stayed high after start");
  AST_CONV_LEN: assert property (s_start |=> s_busy ##1 eoc_in) else $error("conversion length wrong");
  AST_EOC_HOLDS: assert property (eoc_in && !(!wr_n_in && !cs_n_in && $past(wr_n_in)) |=> eoc_in)
    else $error("eoc dropped without start");
  AST_FALL_CAUSE: assert property ($fell(eoc_in) |-> $past(!wr_n_in && !cs_n_in))
    else $error("eoc fell without write");
  // Result latch lands two cycles before eoc is seen rising
  AST_OVR_LATCHED: assert property ($changed(overrange_flag_in) |-> ##2 $rose(eoc_in))
    else $error("overrange changed outside latch");
  AST_OE_ON: assert property (!cs_n_in && !rd_n_in |=> data_oe_in) else $error("bus not driven on read");
  AST_OE_OFF: assert property (cs_n_in || rd_n_in |=> !data_oe_in) else $error("bus driven without read");
  AST_HIGH_BYTE: assert property (data_oe_in && !bus_wide_in && $past(byte_select_in) && $stable(eoc_in)
    && $stable(overrange_flag_in) |-> data_bus_in[7:6] == {overrange_flag_in, eoc_in})
    else $error("high byte wrong");

  COV_START: cover property (s_start);
endmodule : sar_link_checker

/* File: tb/test_sar_adc_conversion_host_port.sv */
/*
  Self-checking bench: host end and converter end joined by the link interface.
  Assumes a behavioural comparator driven from the bench on compare_in.
*/
`timescale 1ns/1ns
module test_sar_adc_conversion_host_port;
  logic        ref_clk_in, rst_in, compare_in, conv_req_in, cal_req_in;
  logic [2:0]  conv_channel_in, mux_channel_out;
  logic        auto_zero_out, hold_out, busy_out, done_out, sample_bad_out;
  logic [16:0] trial_out, first_trial;
  logic [14:0] sample_out;
  logic [13:0] offset_out, span_out;
  logic        cmp_high, cmp_by_chan;
  logic [2:0]  chans[$];
  int          mismatches, num_checks, low_cycles, az_cycles, hold_gaps;

  sar_link_if link();
  sar_converter sar_converter_inst (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .compare_in(compare_in),
    .auto_zero_out(auto_zero_out), .trial_out(trial_out), .link(link));
  sar_host sar_host_inst (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .conv_req_in(conv_req_in),
    .cal_req_in(cal_req_in), .conv_channel_in(conv_channel_in), .mux_channel_out(mux_channel_out),
    .hold_out(hold_out), .busy_out(busy_out), .done_out(done_out), .sample_out(sample_out),
    .sample_bad_out(sample_bad_out), .offset_out(offset_out), .span_out(span_out), .link(link));
  sar_link_checker sar_link_checker_inst (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .cs_n_in(link.cs_n),
    .rd_n_in(link.rd_n), .wr_n_in(link.wr_n), .bus_wide_in(link.bus_wide),
    .byte_select_in(link.byte_select), .data_bus_in(link.data_bus), .data_oe_in(link.data_oe),
    .eoc_in(link.eoc), .overrange_flag_in(link.overrange_flag));

  // Comparator stand-in: fixed level, or high only on the reference channel
  always @(negedge ref_clk_in) begin
    compare_in <= cmp_high | (cmp_by_chan && mux_channel_out == sar_pkg::CH_REFERENCE);
  end

  task check(input logic [16:0] got, input logic [16:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task report_and_stop;
    if (mismatches == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : report_and_stop

  // Request held until the host goes busy, then watched until done
  task run_op(input logic cal);
    int n;
    low_cycles = 0;
    az_cycles = 0;
    hold_gaps = 0;
    n = 0;
    chans.delete();
    @(negedge ref_clk_in);
    if (cal) cal_req_in = 1'b1;
    else conv_req_in = 1'b1;
    while (done_out !== 1'b1 && n < 400) begin
      @(negedge ref_clk_in);
      if (busy_out === 1'b1) begin
        cal_req_in = 1'b0;
        conv_req_in = 1'b0;
      end
      if (link.eoc === 1'b0) begin
        low_cycles++;
        if (low_cycles % 20 == 1) chans.push_back(mux_channel_out);
        if (low_cycles == 1) first_trial = trial_out;
        if (hold_out !== 1'b1) hold_gaps++;
      end
      if (auto_zero_out === 1'b1) az_cycles++;
      n++;
    end
    if (n >= 400) mismatches++;
  endtask : run_op

  task t_conv_zero;
    cmp_high = 1'b0;
    cmp_by_chan = 1'b0;
    conv_channel_in = 3'h5;
    run_op(1'b0);
    check(17'(low_cycles), 17'h00014);
    check(first_trial, 17'h11000);
    check(17'(az_cycles), 17'h00003);
    check(17'(chans[0]), 17'h00005);
    check(17'(sample_out), 17'h00000);
    check(17'(link.overrange_flag), 17'h00000);
    check(17'(sample_bad_out), 17'h00000);
    check(17'(hold_gaps), 17'h00000);
    check(17'(hold_out), 17'h00000);
  endtask : t_conv_zero

  task t_conv_over;
    cmp_high = 1'b1;
    conv_channel_in = 3'h2;
    run_op(1'b0);
    check(17'(low_cycles), 17'h00014);
    check(17'(sample_out[14]), 17'h00001);
    check(17'(sample_out), 17'h07FFF);
    check(17'(link.overrange_flag), 17'h00001);
    check(17'(sample_bad_out), 17'h00001);
  endtask : t_conv_over

  task t_cal;
    cmp_high = 1'b0;
    cmp_by_chan = 1'b1;
    run_op(1'b1);
    check(17'(low_cycles), 17'h00028);
    check(17'(az_cycles), 17'h00006);
    check(17'(chans.size()), 17'h00002);
    check(17'(chans[0]), 17'(sar_pkg::CH_GROUND));
    check(17'(chans[1]), 17'(sar_pkg::CH_REFERENCE));
    check(17'(offset_out), 17'h00000);
    check(17'(span_out), 17'(sample_out[13:0]));
    cmp_by_chan = 1'b0;
  endtask : t_cal

  // Clock at 100 MHz
  initial begin
    ref_clk_in = 1'b0;
    forever #5 ref_clk_in = ~ref_clk_in;
  end

  // Hang guard, far beyond the few hundred cycles the tests need
  initial begin
    #200000;
    mismatches++;
    report_and_stop();
  end

  // Main sequence; over then zero checks the overrange flag clears
  initial begin
    mismatches = 0;
    num_checks = 0;
    rst_in = 1'b1;
    conv_req_in = 1'b0;
    cal_req_in = 1'b0;
    conv_channel_in = 3'h0;
    cmp_high = 1'b0;
    cmp_by_chan = 1'b0;
    repeat (6) @(negedge ref_clk_in);
    rst_in = 1'b0;
    t_conv_zero();
    t_conv_over();
    t_conv_zero();
    t_cal();
    report_and_stop();
  end
endmodule : test_sar_adc_conversion_host_port
